//--- sarc_control.sv
// Overview of operation
// - Strobe fall switches sampling to hold without waiting for a clock edge.
// - Unsynchronised strobe still converts; start may slip one clock.
// - First conversion clock drives data low out of high impedance.
// - Strobe low through conversion and at 13th clock enters power-down.
// - Power-down lasts until strobe rises, then sampling resumes.
// - First conversion after power-down is valid, no dummy cycle.
// - Least significant bit is driven during the 13th clock.
// - Strobe up before 12th end, down in 13th resends result LSB first.
// - LSB-first readout powers down at 13th clock, resumes on strobe rise.
// - Strobe up then down before 13th clock aborts the conversion at once.
// - Strobe fall puts data into high impedance at once; host latches first.
// - Result is straight unsigned binary, zero input gives all-zero code.
// - Result leaves MSB first on the clock, from the current conversion.
`timescale 1ns/1ps
`include "sarc_defines.svh"

module sarc_control
	import sarc_pkg::*;
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	// Pins from the host
	input  wire logic                    conversion_strobe,
	input  wire logic                    conversion_clock,
	// Analog front end
	input  wire logic                    comparator_high,
	output logic [`SARC_RES_W-1:0]       dac_code,
	output logic                         track_hold,
	output logic                         power_down,
	// Serial data pin
	output logic                         data_out,
	output logic                         data_oe_n,
	// Result of the last conversion
	output logic [`SARC_RES_W-1:0]       result_code
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic [2:0] stb_sync_ff;
	logic [2:0] clk_sync_ff;
	logic [1:0] cmp_sync_ff;
	logic       stb_fall;
	logic       stb_rise;
	logic       stb_low;
	logic       clk_fall;
	logic       cmp_bit;

	// Two stages before use, third stage only for edges
	always_ff @(posedge core_clk) begin
		if (srst) begin
			stb_sync_ff <= 3'h7;
			clk_sync_ff <= 3'h0;
			cmp_sync_ff <= 2'h0;
		end else begin
			stb_sync_ff <= {stb_sync_ff[1:0], conversion_strobe};
			clk_sync_ff <= {clk_sync_ff[1:0], conversion_clock};
			cmp_sync_ff <= {cmp_sync_ff[0], comparator_high};
		end
	end

	// Edges seen on the synchronised pins, any phase to the clock
	assign stb_fall = stb_sync_ff[2] & ~stb_sync_ff[1];
	assign stb_rise = ~stb_sync_ff[2] & stb_sync_ff[1];
	assign stb_low  = ~stb_sync_ff[1];
	assign clk_fall = clk_sync_ff[2] & ~clk_sync_ff[1];
	assign cmp_bit  = cmp_sync_ff[1];

	// ****************************************************************
	// Conversion sequencer
	// ****************************************************************
	sarc_state_t                 state_ff;
	sarc_state_t                 nxt_state;
	logic [`SARC_CYC_W-1:0]      cyc_ff;
	logic [`SARC_CYC_W-1:0]      nxt_cyc;
	logic [`SARC_CYC_W-1:0]      lsb_idx_ff;
	logic [`SARC_CYC_W-1:0]      nxt_lsb_idx;
	logic [`SARC_RES_W-1:0]      result_ff;
	logic [`SARC_RES_W-1:0]      nxt_result;
	logic                        rose_ff;
	logic                        nxt_rose;
	logic                        dout_ff;
	logic                        nxt_dout;
	logic                        oe_n_ff;
	logic                        nxt_oe_n;
	logic [`SARC_CYC_W-1:0]      bit_idx;

	// Bit under trial in the current clock
	assign bit_idx = `SARC_CYC_MSB_REF - cyc_ff;

	// Next state of the sequencer
	always_comb begin
		nxt_state   = state_ff;
		nxt_cyc     = cyc_ff;
		nxt_lsb_idx = lsb_idx_ff;
		nxt_result  = result_ff;
		nxt_rose    = rose_ff;
		nxt_dout    = dout_ff;
		nxt_oe_n    = oe_n_ff;
		unique case (state_ff)
			SARC_SAMPLE: begin
				if (stb_fall) begin
					nxt_state  = SARC_HOLD;
					nxt_result = `SARC_RES_ZERO;
				end
			end
			SARC_HOLD: begin
				if (stb_rise) begin
					nxt_state = SARC_SAMPLE;
				end else if (clk_fall) begin
					nxt_state = SARC_CONVERSION_STROBE;
					nxt_cyc   = `SARC_CYC_FIRST;
					nxt_rose  = 1'h0;
					nxt_dout  = 1'h0;
					nxt_oe_n  = 1'h0;
				end
			end
			SARC_CONVERSION_STROBE: begin
				if (stb_rise) begin
					nxt_rose = 1'h1;
				end
				if (stb_fall && rose_ff) begin
					nxt_oe_n = 1'h1;
					if (cyc_ff == `SARC_CYC_LSB) begin
						nxt_state   = SARC_LSBF;
						nxt_lsb_idx = `SARC_LSBF_FIRST;
					end else begin
						nxt_state = SARC_PDOWN;
					end
				end else if (clk_fall) begin
					if (cyc_ff < `SARC_CYC_LSB) begin
						// Straight binary: kept bit means input at or above trial
						nxt_result[bit_idx] = cmp_bit;
						nxt_dout            = cmp_bit;
						nxt_cyc             = cyc_ff + `SARC_CYC_STEP;
					end else begin
						nxt_oe_n = 1'h1;
						if (stb_low && !rose_ff) begin
							nxt_state = SARC_PDOWN;
						end else begin
							nxt_state = SARC_SAMPLE;
						end
					end
				end
			end
			SARC_LSBF: begin
				if (stb_rise) begin
					nxt_state = SARC_SAMPLE;
					nxt_oe_n  = 1'h1;
				end else if (clk_fall) begin
					if (lsb_idx_ff <= `SARC_LSBF_LAST) begin
						nxt_dout    = result_ff[lsb_idx_ff];
						nxt_oe_n    = 1'h0;
						nxt_lsb_idx = lsb_idx_ff + `SARC_CYC_STEP;
					end else begin
						nxt_state = SARC_PDOWN;
						nxt_oe_n  = 1'h1;
					end
				end
			end
			SARC_PDOWN: begin
				if (stb_rise) begin
					nxt_state = SARC_SAMPLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_ff   <= SARC_SAMPLE;
			cyc_ff     <= `SARC_CYC_FIRST;
			lsb_idx_ff <= `SARC_LSBF_FIRST;
			result_ff  <= `SARC_RES_ZERO;
			rose_ff    <= 1'h0;
			dout_ff    <= 1'h0;
			oe_n_ff    <= 1'h1;
		end else begin
			state_ff   <= nxt_state;
			cyc_ff     <= nxt_cyc;
			lsb_idx_ff <= nxt_lsb_idx;
			result_ff  <= nxt_result;
			rose_ff    <= nxt_rose;
			dout_ff    <= nxt_dout;
			oe_n_ff    <= nxt_oe_n;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	genvar gi;

	// Trial code: decided bits plus the bit under trial
	generate
		for (gi = 0; gi < `SARC_RES_W; gi++) begin : g_dac
			assign dac_code[gi] = result_ff[gi] |
				((state_ff == SARC_CONVERSION_STROBE) && (cyc_ff < `SARC_CYC_LSB) &&
				 (bit_idx == `SARC_CYC_W'(gi)));
		end
	endgenerate

	// Strobe fall releases the pin in the very cycle it is seen
	assign data_oe_n   = oe_n_ff | stb_fall;
	assign data_out    = dout_ff;
	assign result_code = result_ff;
	assign track_hold  = (state_ff != SARC_SAMPLE);

	// Sleep from the 13th clock on while strobe stays low, after an abort, and through any LSB-first readout
	assign power_down = (state_ff == SARC_PDOWN) ||
		(state_ff == SARC_LSBF) ||
		((state_ff == SARC_CONVERSION_STROBE) && (cyc_ff == `SARC_CYC_LSB) &&
		 stb_low && !rose_ff);

endmodule

//--- sarc_control_props.sv
`timescale 1ns/1ps
// ****
// Checker of the serial conversion pins
// ****
module sarc_control_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// Host pins and analog side
	input wire logic        conversion_strobe,
	input wire logic        conversion_clock,
	input wire logic        comparator_high,
	input wire logic [11:0] dac_code,
	input wire logic        track_hold,
	input wire logic        power_down,
	// Serial data and result
	input wire logic        data_out,
	input wire logic        data_oe_n,
	input wire logic [11:0] result_code
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Pin relations over time
	a_hold_on_fall: assert property (
		$fell(conversion_strobe) && !track_hold |-> ##[2:4] track_hold)
		else $error("no hold");
	a_first_low: assert property (
		$fell(data_oe_n) && !power_down |-> !data_out)
		else $error("start bit high");
	a_dac_msb: assert property (
		$fell(data_oe_n) && !power_down |-> dac_code == 12'h800)
		else $error("bad trial");
	a_bit_on_clock: assert property (
		!data_oe_n && $changed(data_out) |-> !conversion_clock)
		else $error("bit moved");
	a_oe_on_fall: assert property (
		$fell(conversion_strobe) |-> ##[2:4] data_oe_n)
		else $error("still driving");
	a_pdown_stays: assert property (
		power_down && !conversion_strobe |=> power_down)
		else $error("woke early");
	a_pdown_exit: assert property (
		conversion_strobe [*5] |-> !power_down)
		else $error("no wake");
	a_idle_hiz: assert property (
		!track_hold |-> data_oe_n)
		else $error("driving idle");
	cover property ($rose(power_down));
	cover property ($fell(data_oe_n) && power_down);
	cover property ($rose(track_hold));
endmodule
bind sarc_control sarc_control_props i_sarc_control_props (
	.core_clk(core_clk), .srst(srst), .conversion_strobe(conversion_strobe),
	.conversion_clock(conversion_clock), .comparator_high(comparator_high),
	.dac_code(dac_code), .track_hold(track_hold), .power_down(power_down),
	.data_out(data_out), .data_oe_n(data_oe_n), .result_code(result_code));

//--- sarc_defines.svh
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// ****************************************************************
// Result and cycle counting
// ****************************************************************
`define SARC_RES_W        12
`define SARC_CYC_W        4
`define SARC_RES_ZERO     12'h000
`define SARC_CYC_FIRST    4'h1
`define SARC_CYC_MSB_REF  4'hc
`define SARC_CYC_LSB      4'hd
`define SARC_LSBF_FIRST   4'h1
`define SARC_LSBF_LAST    4'hb
`define SARC_CYC_STEP     4'h1

`endif

//--- sarc_host_model.sv
`timescale 1ns/1ps
module sarc_host_model (
	// Clock
	input wire logic        core_clk,
	// Pins toward the converter
	output logic            conversion_strobe,
	output logic            conversion_clock,
	input wire logic        data_out,
	input wire logic        data_oe_n,
	// Analog source
	input wire logic [11:0] vin,
	input wire logic [11:0] dac_code,
	output logic            comparator_high
);
	logic [1:0] smp [0:31];
	logic       oe_at_fall;
	logic       data_pin;
	// Held input compared with the trial code
	assign comparator_high = (vin >= dac_code);
	// Line pulled up while the converter leaves it floating
	assign data_pin = data_oe_n ? 1'h1 : data_out;
	// Strobe parked high and clock low before the first frame
	initial begin
		conversion_strobe = 1'h1;
		conversion_clock = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Frame of n clocks, strobe moved after the bit of a cycle is latched
	task automatic run(input int n, input int up, input int dn);
		tick(1);
		conversion_strobe <= 1'h1;
		tick(16);
		conversion_strobe <= 1'h0;
		tick(8);
		for (int i = 0; i < n; i++) begin
			conversion_clock <= 1'h1;
			tick(2);
			@(negedge core_clk) smp[i] = {data_oe_n, data_pin};
			tick(1);
			if (i == up) conversion_strobe <= 1'h1;
			if (i == dn) conversion_strobe <= 1'h0;
			tick(3);
			conversion_clock <= 1'h0;
			tick(1);
			@(negedge core_clk) if (i == dn) oe_at_fall = data_oe_n;
			tick(3);
		end
		@(negedge core_clk);
	endtask
endmodule

//--- sarc_pkg.sv
// ****************************************************************
// Types of the conversion control
// ****************************************************************
package sarc_pkg;
	typedef enum logic [2:0] {
		SARC_SAMPLE,
		SARC_HOLD,
		SARC_CONVERSION_STROBE,
		SARC_LSBF,
		SARC_PDOWN
	} sarc_state_t;
endpackage

//--- test_sarc_control.sv
`timescale 1ns/1ps
module test_sarc_control;
	logic        core_clk = 1'h0;
	logic        srst = 1'h1;
	logic [11:0] vin = 12'h000;
	logic [11:0] dac_code, result_code, w;
	logic        conversion_strobe, conversion_clock, comparator_high;
	logic        track_hold, power_down, data_out, data_oe_n;
	int          errors = 0, n_checks = 0, cycles = 0;
	// Clock
	always #12.5 core_clk = ~core_clk;
	sarc_control i_sarc_control (.core_clk(core_clk), .srst(srst),
		.conversion_strobe(conversion_strobe), .dac_code(dac_code),
		.conversion_clock(conversion_clock), .track_hold(track_hold),
		.comparator_high(comparator_high), .power_down(power_down),
		.data_out(data_out), .data_oe_n(data_oe_n), .result_code(result_code));
	sarc_host_model i_sarc_host_model (.core_clk(core_clk), .vin(vin),
		.conversion_strobe(conversion_strobe), .dac_code(dac_code),
		.conversion_clock(conversion_clock), .comparator_high(comparator_high),
		.data_out(data_out), .data_oe_n(data_oe_n));
	task automatic chk(input string what, input logic [11:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Plain readout ending in power-down
	task automatic t_normal(input logic [11:0] v);
		vin <= v;
		i_sarc_host_model.run(16, -1, -1);
		for (int j = 0; j < 12; j++) w[11-j] = i_sarc_host_model.smp[2+j][0];
		chk("start bit", {10'h0, i_sarc_host_model.smp[1]}, 12'h000);
		chk("word", w, v);
		for (int j = 0; j < 12; j++) w[j] = i_sarc_host_model.smp[2+j][1];
		chk("enables", w, 12'h000);
		chk("idle", {11'h0, i_sarc_host_model.smp[14][1]}, 12'h001);
		chk("sleep", {11'h0, power_down}, 12'h001);
		chk("result", result_code, v);
	endtask
	// Strobe rise leaves power-down
	task automatic t_wake();
		i_sarc_host_model.tick(1);
		i_sarc_host_model.conversion_strobe <= 1'h1;
		i_sarc_host_model.tick(8);
		chk("wake", {10'h0, power_down, track_hold}, 12'h000);
	endtask
	// Repeat of the word starting at the low end
	task automatic t_lsb(input logic [11:0] v);
		vin <= v;
		i_sarc_host_model.run(26, 6, 13);
		w[0] = i_sarc_host_model.smp[13][0];
		for (int k = 0; k < 11; k++) w[1+k] = i_sarc_host_model.smp[14+k][0];
		chk("lsb word", w, v);
		chk("hiz", {11'h0, i_sarc_host_model.oe_at_fall}, 12'h001);
		chk("end", {10'h0, i_sarc_host_model.smp[25][1], power_down},
			12'h003);
	endtask
	// Abort after five decided bits
	task automatic t_short(input logic [11:0] v);
		vin <= v;
		i_sarc_host_model.run(16, 3, 6);
		chk("hiz", {11'h0, i_sarc_host_model.oe_at_fall}, 12'h001);
		chk("abort", {11'h0, i_sarc_host_model.smp[7][1]}, 12'h001);
		chk("partial", result_code, v & 12'hf80);
		chk("sleep", {11'h0, power_down}, 12'h001);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'h0;
		i_sarc_host_model.tick(3);
		t_normal(12'ha5c);
		t_normal(12'h000);
		t_normal(12'hfff);
		t_wake();
		t_lsb(12'h3c5);
		t_wake();
		t_short(12'hb6d);
		t_wake();
		give_verdict();
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			give_verdict();
		end
	end
endmodule
